// ---- inc/dect_pkg.sv ----
// Purpose: constants, types and register map of the dual counter/timer
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes: registers are 32-bit words at byte offsets below
package dect_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned NUM_CH    = 2;
  localparam int unsigned NUM_SRC   = 19;
  localparam int unsigned NUM_LINE  = 4;
  localparam int unsigned NUM_USER  = 4;
  localparam int unsigned NUM_LOGIC = 2;
  localparam int unsigned IRQ_W     = 6;
  // status bit positions, one pair of bits per event kind
  localparam int unsigned IRQ_START_LSB = 0;
  localparam int unsigned IRQ_END_LSB   = 2;
  localparam int unsigned IRQ_CLEAR_LSB = 4;
  // microsecond tick from the core clock
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADR_CHANNEL_PICK  = 6'h00;
  localparam logic [ADDR_W-1:0] ADR_COUNT_CHOICE  = 6'h04;
  localparam logic [ADDR_W-1:0] ADR_COUNT_POL     = 6'h08;
  localparam logic [ADDR_W-1:0] ADR_START_DELAY   = 6'h0C;
  localparam logic [ADDR_W-1:0] ADR_END_LENGTH    = 6'h10;
  localparam logic [ADDR_W-1:0] ADR_START_CHOICE  = 6'h14;
  localparam logic [ADDR_W-1:0] ADR_START_POL     = 6'h18;
  localparam logic [ADDR_W-1:0] ADR_CLEAR_CHOICE  = 6'h1C;
  localparam logic [ADDR_W-1:0] ADR_CLEAR_POL     = 6'h20;
  localparam logic [ADDR_W-1:0] ADR_LIVE_TALLY    = 6'h24;
  localparam logic [ADDR_W-1:0] ADR_CHANNEL_STATE = 6'h28;
  localparam logic [ADDR_W-1:0] ADR_TALLY_CAPT    = 6'h2C;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS    = 6'h30;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK      = 6'h34;
  typedef enum logic [4:0] {
    SRC_OFF = 5'h00, SRC_TICK = 5'h01,
    SRC_LINE0 = 5'h02, SRC_LINE1 = 5'h03,
    SRC_LINE2 = 5'h04, SRC_LINE3 = 5'h05,
    SRC_USER0 = 5'h06, SRC_USER1 = 5'h07,
    SRC_USER2 = 5'h08, SRC_USER3 = 5'h09,
    SRC_C0_START = 5'h0A, SRC_C1_START = 5'h0B,
    SRC_C0_END = 5'h0C, SRC_C1_END = 5'h0D,
    SRC_LOGIC0 = 5'h0E, SRC_LOGIC1 = 5'h0F,
    SRC_EXP_START = 5'h10, SRC_EXP_END = 5'h11,
    SRC_FRAME_WAIT = 5'h12
  } dect_src_t;
  typedef enum logic [2:0] {
    POL_LEVEL_LOW = 3'h0, POL_LEVEL_HIGH = 3'h1, POL_FALLING = 3'h2,
    POL_RISING = 3'h3, POL_ANY_EDGE = 3'h4
  } dect_pol_t;
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0, ST_ACTIVE = 2'h1, ST_DONE = 2'h2
  } dect_state_t;
  typedef struct packed {
    dect_src_t          cnt_src;
    dect_pol_t          cnt_pol;
    dect_src_t          start_src;
    dect_pol_t          start_pol;
    dect_src_t          clr_src;
    dect_pol_t          clr_pol;
    logic [DATA_W-1:0]  delay;
    logic [DATA_W-1:0]  duration;
  } dect_cfg_t;
  localparam logic [DATA_W-1:0] DELAY_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DURATION_RST = 32'h0000_0000;
  localparam dect_cfg_t CFG_RST = '{
    cnt_src: SRC_OFF, cnt_pol: POL_RISING,
    start_src: SRC_OFF, start_pol: POL_RISING,
    clr_src: SRC_OFF, clr_pol: POL_RISING,
    delay: DELAY_RST, duration: DURATION_RST};
  localparam logic [IRQ_W-1:0] MASK_RST = 6'h00;
endpackage : dect_pkg

// ---- src/dect_qual.sv ----
// Purpose: pick one source from the vector and qualify it by activation
// Assumes: source vector already in the core clock domain
// Notes: a change of choice can look like one edge; software should
//        reconfigure while the channel is idle
`timescale 1ns/1ps
module dect_qual (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_nrst,
  input  wire logic [dect_pkg::NUM_SRC-1:0]  i_src_vec,
  input  wire dect_pkg::dect_src_t           i_choice,
  input  wire dect_pkg::dect_pol_t           i_pol,
  output logic                               o_hit
);
  logic sel_now;
  logic sel_prev_q;

  // selected level, previous copy for edge detection
  assign sel_now = i_src_vec[i_choice];

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      sel_prev_q <= 1'b0;
    else
      sel_prev_q <= sel_now;
  end

  // off never fires, even for level low
  always_comb
  begin
    o_hit = 1'b0;
    if (i_choice != dect_pkg::SRC_OFF)
    begin
      unique case (i_pol)
        dect_pkg::POL_LEVEL_LOW:  o_hit = !sel_now;
        dect_pkg::POL_LEVEL_HIGH: o_hit = sel_now;
        dect_pkg::POL_FALLING:    o_hit = sel_prev_q && !sel_now;
        dect_pkg::POL_RISING:     o_hit = !sel_prev_q && sel_now;
        dect_pkg::POL_ANY_EDGE:   o_hit = sel_prev_q != sel_now;
        default:                  o_hit = 1'b0;
      endcase
    end
  end
endmodule : dect_qual

// ---- src/dect_top.sv ----
// Purpose: dual counter/timer with register port and event interrupt
// Assumes: line inputs are pins; other sources come from core-clock logic
// Notes: read data valid only in the cycle after the read strobe
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dect_top (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_nrst,
  input  wire logic [dect_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [dect_pkg::DATA_W-1:0]     i_wdata,
  input  wire logic                            i_wr,
  input  wire logic                            i_rd,
  output logic      [dect_pkg::DATA_W-1:0]     o_rdata,
  input  wire logic [dect_pkg::NUM_LINE-1:0]   i_line,
  input  wire logic [dect_pkg::NUM_USER-1:0]   i_user_out,
  input  wire logic [dect_pkg::NUM_LOGIC-1:0]  i_logic_blk,
  input  wire logic                            i_exp_start,
  input  wire logic                            i_exp_end,
  input  wire logic                            i_frame_wait,
  output logic      [dect_pkg::NUM_CH-1:0]     o_start_evt,
  output logic      [dect_pkg::NUM_CH-1:0]     o_end_evt,
  output logic                                 o_irq
);
  localparam int unsigned DW = dect_pkg::DATA_W;
  localparam int unsigned TW = $clog2(dect_pkg::TICK_CYC);

  logic [TW-1:0]                    tick_cnt_q;
  logic                             tick_q;
  logic [dect_pkg::NUM_LINE-1:0]    line_s1_q;
  logic [dect_pkg::NUM_LINE-1:0]    line_s2_q;
  logic [dect_pkg::NUM_SRC-1:0]     src_vec;
  logic                             pick_q;
  dect_pkg::dect_cfg_t              cfg_q     [dect_pkg::NUM_CH];
  dect_pkg::dect_state_t            state_q   [dect_pkg::NUM_CH];
  logic [DW-1:0]                    tally_q   [dect_pkg::NUM_CH];
  logic [DW-1:0]                    capt_q    [dect_pkg::NUM_CH];
  logic [DW-1:0]                    tally_inc [dect_pkg::NUM_CH];
  logic                             start_q   [dect_pkg::NUM_CH];
  logic                             end_q     [dect_pkg::NUM_CH];
  logic                             clr_q     [dect_pkg::NUM_CH];
  logic                             cnt_hit   [dect_pkg::NUM_CH];
  logic                             trig_hit  [dect_pkg::NUM_CH];
  logic                             clr_hit   [dect_pkg::NUM_CH];
  logic [dect_pkg::IRQ_W-1:0]       sts_q;
  logic [dect_pkg::IRQ_W-1:0]       sts_d;
  logic [dect_pkg::IRQ_W-1:0]       sts_set;
  logic [dect_pkg::IRQ_W-1:0]       mask_q;
  logic [DW-1:0]                    rdata_q;
  logic                             irq_q;
  logic [dect_pkg::NUM_CH-1:0]      start_evt_q;
  logic [dect_pkg::NUM_CH-1:0]      end_evt_q;
  logic [4:0]                       wr_src;

  // microsecond tick: one-cycle pulse every TICK_CYC clocks
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TW'(dect_pkg::TICK_CYC - 1))
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // line pins are asynchronous, so two flops before any use
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      line_s1_q <= '0;
      line_s2_q <= '0;
    end
    else
    begin
      line_s1_q <= i_line;
      line_s2_q <= line_s1_q;
    end
  end

  // source vector in enum order; own events come from flops, no loop
  assign src_vec = {i_frame_wait, i_exp_end, i_exp_start, i_logic_blk,
                    end_q[1], end_q[0], start_q[1], start_q[0],
                    i_user_out, line_s2_q, tick_q, 1'b0};

  // out-of-range source codes fold to off so the select stays in range
  assign wr_src = (i_wdata[4:0] < 5'(dect_pkg::NUM_SRC)) ?
                  i_wdata[4:0] : 5'h00;

  // channel selector
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      pick_q <= 1'b0;
    else if (i_wr && i_addr == dect_pkg::ADR_CHANNEL_PICK)
      pick_q <= i_wdata[0];
  end

  genvar c;
  generate
    for (c = 0; c < dect_pkg::NUM_CH; c++)
    begin : g_ch
      logic wr_ch;
      logic go;

      assign wr_ch = i_wr && (pick_q == 1'(c));
      assign tally_inc[c] = tally_q[c] + 1'b1;
      // with no start source the channel runs as soon as it waits
      assign go = (cfg_q[c].start_src == dect_pkg::SRC_OFF) ||
                  trig_hit[c];

      dect_qual u_cnt (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_src_vec  (src_vec),
        .i_choice   (cfg_q[c].cnt_src),
        .i_pol      (cfg_q[c].cnt_pol),
        .o_hit      (cnt_hit[c])
      );

      dect_qual u_start (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_src_vec  (src_vec),
        .i_choice   (cfg_q[c].start_src),
        .i_pol      (cfg_q[c].start_pol),
        .o_hit      (trig_hit[c])
      );

      dect_qual u_clr (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_src_vec  (src_vec),
        .i_choice   (cfg_q[c].clr_src),
        .i_pol      (cfg_q[c].clr_pol),
        .o_hit      (clr_hit[c])
      );

      // per-channel configuration writes
      always_ff @(posedge i_core_clk)
      begin
        if (!i_nrst)
          cfg_q[c] <= dect_pkg::CFG_RST;
        else if (wr_ch)
        begin
          unique case (i_addr)
            dect_pkg::ADR_COUNT_CHOICE:
              cfg_q[c].cnt_src <= dect_pkg::dect_src_t'(wr_src);
            dect_pkg::ADR_COUNT_POL:
              cfg_q[c].cnt_pol <= dect_pkg::dect_pol_t'(i_wdata[2:0]);
            dect_pkg::ADR_START_DELAY:
              cfg_q[c].delay <= i_wdata;
            dect_pkg::ADR_END_LENGTH:
              cfg_q[c].duration <= i_wdata;
            dect_pkg::ADR_START_CHOICE:
            begin
              cfg_q[c].start_src <= dect_pkg::dect_src_t'(wr_src);
              if (wr_src != 5'h00)
                cfg_q[c].clr_src <= dect_pkg::SRC_OFF;
            end
            dect_pkg::ADR_START_POL:
              cfg_q[c].start_pol <= dect_pkg::dect_pol_t'(i_wdata[2:0]);
            dect_pkg::ADR_CLEAR_CHOICE:
            begin
              cfg_q[c].clr_src <= dect_pkg::dect_src_t'(wr_src);
              if (wr_src != 5'h00)
                cfg_q[c].start_src <= dect_pkg::SRC_OFF;
            end
            dect_pkg::ADR_CLEAR_POL:
              cfg_q[c].clr_pol <= dect_pkg::dect_pol_t'(i_wdata[2:0]);
            default:
              cfg_q[c] <= cfg_q[c];
          endcase
        end
      end

      // channel sequencer; clear outranks counting in the same cycle
      always_ff @(posedge i_core_clk)
      begin
        if (!i_nrst)
        begin
          state_q[c] <= dect_pkg::ST_WAIT;
          tally_q[c] <= '0;
          start_q[c] <= 1'b0;
          end_q[c]   <= 1'b0;
          clr_q[c]   <= 1'b0;
        end
        else
        begin
          start_q[c] <= 1'b0;
          end_q[c]   <= 1'b0;
          clr_q[c]   <= clr_hit[c];
          if (clr_hit[c])
          begin
            tally_q[c] <= '0;
            state_q[c] <= dect_pkg::ST_WAIT;
          end
          else
          begin
            unique case (state_q[c])
              dect_pkg::ST_WAIT:
                if (go)
                  state_q[c] <= dect_pkg::ST_ACTIVE;
              dect_pkg::ST_ACTIVE:
                if (cnt_hit[c])
                begin
                  tally_q[c] <= tally_inc[c];
                  if (tally_inc[c] == cfg_q[c].delay)
                    start_q[c] <= 1'b1;
                  if (tally_inc[c] == cfg_q[c].duration)
                  begin
                    end_q[c]   <= 1'b1;
                    state_q[c] <= dect_pkg::ST_DONE;
                  end
                end
              dect_pkg::ST_DONE:
                if (trig_hit[c])
                begin
                  tally_q[c] <= '0;
                  state_q[c] <= dect_pkg::ST_ACTIVE;
                end
              default:
                state_q[c] <= dect_pkg::ST_WAIT;
            endcase
          end
        end
      end

      // captured tally: hardware capture beats a software write
      always_ff @(posedge i_core_clk)
      begin
        if (!i_nrst)
          capt_q[c] <= '0;
        else if (clr_hit[c])
          capt_q[c] <= tally_q[c];
        else if (wr_ch && i_addr == dect_pkg::ADR_TALLY_CAPT)
          capt_q[c] <= i_wdata;
      end

      assign sts_set[dect_pkg::IRQ_START_LSB + c] = start_q[c];
      assign sts_set[dect_pkg::IRQ_END_LSB + c]   = end_q[c];
      assign sts_set[dect_pkg::IRQ_CLEAR_LSB + c] = clr_q[c];
    end
  endgenerate

  // sticky status; an event in the reading cycle survives the clear
  always_comb
  begin
    sts_d = sts_q;
    if (i_rd && i_addr == dect_pkg::ADR_IRQ_STATUS)
      sts_d = '0;
    sts_d = sts_d | sts_set;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      sts_q <= '0;
    else
      sts_q <= sts_d;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      mask_q <= dect_pkg::MASK_RST;
    else if (i_wr && i_addr == dect_pkg::ADR_IRQ_MASK)
      mask_q <= i_wdata[dect_pkg::IRQ_W-1:0];
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      irq_q <= 1'b0;
    else
      irq_q <= |(sts_q & mask_q);
  end

  // event pulses out, registered copies of the channel events
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      start_evt_q <= '0;
      end_evt_q   <= '0;
    end
    else
    begin
      start_evt_q <= {start_q[1], start_q[0]};
      end_evt_q   <= {end_q[1], end_q[0]};
    end
  end

  // read data stands one cycle only; unmapped reads return zero
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      rdata_q <= '0;
    else if (!i_rd)
      rdata_q <= '0;
    else
    begin
      unique case (i_addr)
        dect_pkg::ADR_CHANNEL_PICK:  rdata_q <= DW'(pick_q);
        dect_pkg::ADR_COUNT_CHOICE:  rdata_q <= DW'(cfg_q[pick_q].cnt_src);
        dect_pkg::ADR_COUNT_POL:     rdata_q <= DW'(cfg_q[pick_q].cnt_pol);
        dect_pkg::ADR_START_DELAY:   rdata_q <= cfg_q[pick_q].delay;
        dect_pkg::ADR_END_LENGTH:    rdata_q <= cfg_q[pick_q].duration;
        dect_pkg::ADR_START_CHOICE:
          rdata_q <= DW'(cfg_q[pick_q].start_src);
        dect_pkg::ADR_START_POL:
          rdata_q <= DW'(cfg_q[pick_q].start_pol);
        dect_pkg::ADR_CLEAR_CHOICE:
          rdata_q <= DW'(cfg_q[pick_q].clr_src);
        dect_pkg::ADR_CLEAR_POL:
          rdata_q <= DW'(cfg_q[pick_q].clr_pol);
        dect_pkg::ADR_LIVE_TALLY:    rdata_q <= tally_q[pick_q];
        dect_pkg::ADR_CHANNEL_STATE: rdata_q <= DW'(state_q[pick_q]);
        dect_pkg::ADR_TALLY_CAPT:    rdata_q <= capt_q[pick_q];
        dect_pkg::ADR_IRQ_STATUS:    rdata_q <= DW'(sts_q);
        dect_pkg::ADR_IRQ_MASK:      rdata_q <= DW'(mask_q);
        default:                     rdata_q <= '0;
      endcase
    end
  end

  assign o_rdata     = rdata_q;
  assign o_irq       = irq_q;
  assign o_start_evt = start_evt_q;
  assign o_end_evt   = end_evt_q;
endmodule : dect_top

// ---- test/dect_checker.sv ----
// Purpose: port-level checks of the dual counter/timer
// Assumes: one clock, synchronous active-low reset
// Notes: watches read data, event pulses and interrupt only
`timescale 1ns/1ps
module dect_checker (
  input wire logic                        i_core_clk,
  input wire logic                        i_nrst,
  input wire logic [dect_pkg::ADDR_W-1:0] i_addr,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [dect_pkg::DATA_W-1:0] o_rdata,
  input wire logic [dect_pkg::NUM_CH-1:0] o_start_evt,
  input wire logic [dect_pkg::NUM_CH-1:0] o_end_evt,
  input wire logic                        o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // read data only in the cycle after a read strobe
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  chk_hole_zero: assert property (
    $past(i_rd) && $past(i_addr) > 6'h34 |-> o_rdata == 32'h0000_0000)
    else $error("unmapped address read not zero");
  chk_pick_bit: assert property (
    $past(i_rd) && $past(i_addr) == dect_pkg::ADR_CHANNEL_PICK
    |-> o_rdata[31:1] == 31'h0000_0000)
    else $error("channel pick wider than one bit");
  chk_state_code: assert property (
    $past(i_rd) && $past(i_addr) == dect_pkg::ADR_CHANNEL_STATE
    |-> o_rdata <= 32'h0000_0002)
    else $error("channel state code out of range");
  // outputs quiet on the first edge after reset
  chk_reset_quiet: assert property (
    $past(!i_nrst) |-> o_rdata == 32'h0000_0000 && o_start_evt == 2'h0
    && o_end_evt == 2'h0 && !o_irq)
    else $error("outputs not quiet after reset");
  chk_start_pulse: assert property (
    |o_start_evt |=> (o_start_evt & $past(o_start_evt)) == 2'h0)
    else $error("start event longer than one cycle");
  chk_end_pulse: assert property (
    |o_end_evt |=> (o_end_evt & $past(o_end_evt)) == 2'h0)
    else $error("end event longer than one cycle");
  // irq drops only after a status read or mask write
  chk_irq_fall: assert property (
    $fell(o_irq) |-> $past(i_rd, 2) || $past(i_wr, 2))
    else $error("interrupt dropped without software access");
  cover property (|o_start_evt);
  cover property (|o_end_evt);
  cover property ($fell(o_irq));
endmodule : dect_checker

bind dect_top dect_checker u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_start_evt(o_start_evt), .o_end_evt(o_end_evt), .o_irq(o_irq));

// ---- test/test_dual_event_counter_timer.sv ----
// Purpose: self-checking bench for the dual counter/timer
// Assumes: bench drives every port, no partner model
// Notes: user outputs carry count, start and clear stimulus
`timescale 1ns/1ps
module test_dual_event_counter_timer;
  logic        i_core_clk;
  logic        i_nrst;
  logic [5:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [3:0]  i_line;
  logic [3:0]  i_user_out;
  logic [1:0]  i_logic_blk;
  logic        i_exp_start;
  logic        i_exp_end;
  logic        i_frame_wait;
  logic [1:0]  o_start_evt;
  logic [1:0]  o_end_evt;
  logic        o_irq;
  int          bad_count;
  int          n_compared;
  int          seed;
  int          nseed;
  int          st_n [2];
  int          en_n [2];
  int          d;
  int          n;
  int          k;
  int          e;
  logic [31:0] q;
  int          dl [2];
  int          du [2];
  int          m_st [2];
  int          m_en [2];
  int          capq [$];

  dect_top DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_line(i_line), .i_user_out(i_user_out), .i_logic_blk(i_logic_blk),
    .i_exp_start(i_exp_start), .i_exp_end(i_exp_end),
    .i_frame_wait(i_frame_wait), .o_start_evt(o_start_evt),
    .o_end_evt(o_end_evt), .o_irq(o_irq));

  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // noise on unused sources; a wrong choice decode would count it
  always @(posedge i_core_clk)
  begin
    {i_line, i_logic_blk, i_exp_start, i_exp_end, i_frame_wait}
      <= 9'($random(nseed));
  end

  // event pulses counted per channel
  always @(posedge i_core_clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      st_n[c] += int'(o_start_evt[c] === 1'b1);
      en_n[c] += int'(o_end_evt[c] === 1'b1);
    end
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  // answer sampled once the strobe edge has landed
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rdc

  task automatic setu(input int b, input logic v);
    @(posedge i_core_clk);
    i_user_out[b] <= v;
  endtask : setu

  // two toggles, each held two cycles
  task automatic pulse(input int b);
    repeat (2)
    begin
      setu(b, ~i_user_out[b]);
      @(posedge i_core_clk);
    end
  endtask : pulse

  initial
  begin
    repeat (30000) @(posedge i_core_clk);
    bad_count++;
    close_out();
  end

  initial
  begin
    seed = 32'h21f5f9a8;
    nseed = seed + 1;
    {i_nrst, i_wr, i_rd, i_addr, i_wdata, i_user_out} = '0;
    {i_line, i_logic_blk, i_exp_start, i_exp_end, i_frame_wait} = '0;
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    // reset values, then the two holes past the map; with no start
    // source the channel has already left wait for active
    for (int a = 0; a < 16; a++)
      rdc(6'(a * 4), (a == 2 || a == 6 || a == 8) ? 32'h3 :
          (a == 10) ? 32'h1 : 32'h0);
    wr(dect_pkg::ADR_COUNT_CHOICE, 32'h13);
    rdc(dect_pkg::ADR_COUNT_CHOICE, 32'h0);
    for (int ch = 0; ch < 2; ch++)
    begin
      d = 1 + ($random(seed) & 3);
      n = d + 1 + ($random(seed) & 3);
      wr(dect_pkg::ADR_CHANNEL_PICK, ch);
      rdc(dect_pkg::ADR_CHANNEL_PICK, ch);
      wr(dect_pkg::ADR_START_DELAY, d);
      wr(dect_pkg::ADR_END_LENGTH, n);
      rdc(dect_pkg::ADR_START_DELAY, d);
      rdc(dect_pkg::ADR_END_LENGTH, n);
      wr(dect_pkg::ADR_COUNT_CHOICE, 32'h6);
      rdc(dect_pkg::ADR_CHANNEL_STATE, 32'h1);
      dl[ch] = d;
      du[ch] = n;
      m_st[ch] = 1;
      m_en[ch] = 1;
    end
    // eight rising edges take both channels to their end count
    wr(dect_pkg::ADR_IRQ_MASK, 32'hC);
    repeat (8) pulse(0);
    repeat (4) @(posedge i_core_clk);
    #1;
    chk(o_irq, 1'b1);
    rdc(dect_pkg::ADR_IRQ_STATUS, 32'hF);
    rdc(dect_pkg::ADR_IRQ_STATUS, 32'h0);
    chk(o_irq, 1'b0);
    for (int ch = 0; ch < 2; ch++)
    begin
      chk(st_n[ch], m_st[ch]);
      chk(en_n[ch], m_en[ch]);
      wr(dect_pkg::ADR_CHANNEL_PICK, ch);
      rdc(dect_pkg::ADR_LIVE_TALLY, du[ch]);
      rdc(dect_pkg::ADR_CHANNEL_STATE, 32'h2);
    end
    // clear on user1 rising: capture, zero, run again at once
    wr(dect_pkg::ADR_CHANNEL_PICK, 32'h0);
    wr(dect_pkg::ADR_CLEAR_CHOICE, 32'h7);
    capq.push_back(du[0]);
    pulse(1);
    rdc(dect_pkg::ADR_IRQ_STATUS, 32'h10);
    rdc(dect_pkg::ADR_TALLY_CAPT, capq.pop_front());
    rdc(dect_pkg::ADR_LIVE_TALLY, 32'h0);
    rdc(dect_pkg::ADR_CHANNEL_STATE, 32'h1);
    // start and clear choices shut each other off
    wr(dect_pkg::ADR_START_CHOICE, 32'h8);
    rdc(dect_pkg::ADR_CLEAR_CHOICE, 32'h0);
    rdc(dect_pkg::ADR_START_CHOICE, 32'h8);
    wr(dect_pkg::ADR_CLEAR_CHOICE, 32'h7);
    rdc(dect_pkg::ADR_START_CHOICE, 32'h0);
    // channel 1 counts falling edges and restarts on user3 rising
    wr(dect_pkg::ADR_CHANNEL_PICK, 32'h1);
    wr(dect_pkg::ADR_COUNT_POL, 32'h2);
    wr(dect_pkg::ADR_START_CHOICE, 32'h9);
    pulse(3);
    rdc(dect_pkg::ADR_LIVE_TALLY, 32'h0);
    rdc(dect_pkg::ADR_CHANNEL_STATE, 32'h1);
    // a random run of pulses, model saturates at the end count
    k = 1 + ($random(seed) & 3);
    repeat (k) pulse(0);
    for (int ch = 0; ch < 2; ch++)
    begin
      e = (k < du[ch]) ? k : du[ch];
      m_st[ch] += int'(k >= dl[ch]);
      m_en[ch] += int'(k >= du[ch]);
      if (ch == 0)
        capq.push_back(e);
      wr(dect_pkg::ADR_CHANNEL_PICK, ch);
      rdc(dect_pkg::ADR_LIVE_TALLY, e);
    end
    wr(dect_pkg::ADR_CHANNEL_PICK, 32'h0);
    pulse(1);
    q = capq.pop_front();
    rdc(dect_pkg::ADR_TALLY_CAPT, q);
    for (int ch = 0; ch < 2; ch++)
    begin
      chk(st_n[ch], m_st[ch]);
      chk(en_n[ch], m_en[ch]);
    end
    close_out();
  end
endmodule : test_dual_event_counter_timer
